/* rtl/fcs_host.sv */
// host controller that drives a parallel flash through its command set
// assumes fcs_pkg, an avalon-mm master and a flash on the pin side
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
module fcs_host (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic byte_mode,
	output logic [17:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_b,
	output logic flash_we_b,
	output logic flash_oe_b,
	output logic program_supply_high
);
	typedef enum logic [2:0] {
		FCS_IDLE, FCS_FIRST, FCS_SECOND, FCS_POLL, FCS_POLL_WAIT
	} fcs_state_t;
	typedef enum logic [1:0] {
		FCS_MODE_ARRAY, FCS_MODE_IDENT, FCS_MODE_STATUS, FCS_MODE_SUSPEND
	} fcs_mode_t;

	fcs_state_t state_ff;
	fcs_mode_t mode_ff;
	fcs_pkg::fcs_op_t op_ff;
	logic [17:0] addr_ff;
	logic [15:0] wdata_ff;
	logic [15:0] rdata_ff;
	logic [7:0] status_ff;
	logic busy_ff;
	logic refused_ff;
	logic erasing_ff;
	logic cyc_start;
	logic cyc_write;
	logic [17:0] cyc_addr;
	logic [15:0] cyc_wdata;
	logic cyc_idle;
	logic cyc_done;
	logic [15:0] cyc_rdata;
	logic [7:0] nxt_status;

	// status byte as seen on the low data lane
	function automatic logic [7:0] low_byte(input logic [15:0] v);
		return v[7:0];
	endfunction

	// a command byte placed on the low lane
	function automatic logic [15:0] cmd_word(input logic [7:0] c);
		return {8'h00, c};
	endfunction

	// ------------------------------------------------------------
	// pin cycle engine
	// ------------------------------------------------------------
	fcs_bus_cycle u_cycle (
		.clock(clock),
		.rst_b(rst_b),
		.start(cyc_start),
		.is_write(cyc_write),
		.addr(cyc_addr),
		.wdata(cyc_wdata),
		.idle(cyc_idle),
		.done(cyc_done),
		.rdata_ff(cyc_rdata),
		.flash_addr_ff(flash_addr),
		.flash_dq_out_ff(flash_dq_out),
		.flash_dq_oe_ff(flash_dq_oe),
		.flash_dq_in(flash_dq_in),
		.flash_ce_b_ff(flash_ce_b),
		.flash_we_b_ff(flash_we_b),
		.flash_oe_b_ff(flash_oe_b)
	);

	// ------------------------------------------------------------
	// avalon slave
	// ------------------------------------------------------------
	// writes to the control register wait while an operation runs
	assign avs_waitrequest = avs_write && (avs_address == fcs_pkg::REG_CTRL)
		&& (state_ff != FCS_IDLE);

	// read mux; data from registers
	always_comb begin
		case (avs_address)
			fcs_pkg::REG_ADDR: avs_readdata = {14'h0000, addr_ff};
			fcs_pkg::REG_WDATA: avs_readdata = {16'h0000, wdata_ff};
			fcs_pkg::REG_RDATA: avs_readdata = {16'h0000, rdata_ff};
			fcs_pkg::REG_STATUS: avs_readdata = {20'h00000, refused_ff, erasing_ff,
				busy_ff || (state_ff != FCS_IDLE), mode_ff == FCS_MODE_SUSPEND, status_ff};
			fcs_pkg::REG_CTRL: avs_readdata = {28'h0000000, op_ff};
			default: avs_readdata = fcs_pkg::UNMAPPED_VALUE;
		endcase
	end

	// address and data staging registers
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			addr_ff <= 18'h00000;
			wdata_ff <= 16'h0000;
		end else if (avs_write && avs_address == fcs_pkg::REG_ADDR) begin
			addr_ff <= avs_writedata[17:0];
		end else if (avs_write && avs_address == fcs_pkg::REG_WDATA) begin
			wdata_ff <= avs_writedata[15:0];
		end
	end

	// ------------------------------------------------------------
	// operation sequencer
	// ------------------------------------------------------------
	wire logic go = avs_write && (avs_address == fcs_pkg::REG_CTRL) && (state_ff == FCS_IDLE);
	wire fcs_pkg::fcs_op_t go_op = fcs_pkg::fcs_op_t'(avs_writedata[3:0]);
	// status byte returned by the last poll read
	wire logic [7:0] poll_sr = low_byte(cyc_rdata);
	wire logic supply_block = status_ff[fcs_pkg::SUPPLY_MISSING_BIT];
	wire logic erase_lock = erasing_ff && busy_ff;
	wire logic susp_ok = (go_op == fcs_pkg::FCS_OP_READ_ARRAY)
		|| (go_op == fcs_pkg::FCS_OP_RESUME) || (go_op == fcs_pkg::FCS_OP_READ_STATUS)
		|| (go_op == fcs_pkg::FCS_OP_READ);
	wire logic refuse = (supply_block && (go_op == fcs_pkg::FCS_OP_PROGRAM
		|| go_op == fcs_pkg::FCS_OP_ERASE))
		|| (erase_lock && go_op != fcs_pkg::FCS_OP_SUSPEND && go_op != fcs_pkg::FCS_OP_READ)
		|| (busy_ff && !erasing_ff && go_op != fcs_pkg::FCS_OP_READ)
		|| (mode_ff == FCS_MODE_SUSPEND && !susp_ok)
		|| (go_op == fcs_pkg::FCS_OP_RESUME && !erasing_ff)
		|| (go_op >= fcs_pkg::FCS_OP_NONE);

	assign cyc_start = cyc_idle && (state_ff == FCS_FIRST || state_ff == FCS_SECOND
		|| state_ff == FCS_POLL);
	assign cyc_write = (state_ff == FCS_FIRST) ? (op_ff != fcs_pkg::FCS_OP_READ)
		: (state_ff == FCS_SECOND);

	// first and second cycle contents for each operation
	always_comb begin
		cyc_addr = addr_ff;
		cyc_wdata = wdata_ff;
		if (state_ff == FCS_FIRST) begin
			case (op_ff)
				fcs_pkg::FCS_OP_READ_ARRAY: cyc_wdata = cmd_word(fcs_pkg::CMD_READ_ARRAY);
				fcs_pkg::FCS_OP_IDENTIFY: cyc_wdata = cmd_word(fcs_pkg::CMD_IDENTIFY);
				fcs_pkg::FCS_OP_READ_STATUS: cyc_wdata = cmd_word(fcs_pkg::CMD_READ_STATUS);
				fcs_pkg::FCS_OP_CLEAR_STATUS: cyc_wdata = cmd_word(fcs_pkg::CMD_CLEAR_STATUS);
				fcs_pkg::FCS_OP_PROGRAM: cyc_wdata = cmd_word(fcs_pkg::CMD_PROGRAM_SETUP);
				fcs_pkg::FCS_OP_CANCEL_PROGRAM:
					cyc_wdata = cmd_word(fcs_pkg::CMD_PROGRAM_SETUP_ALT);
				fcs_pkg::FCS_OP_ERASE: cyc_wdata = cmd_word(fcs_pkg::CMD_ERASE_SETUP);
				fcs_pkg::FCS_OP_SUSPEND: cyc_wdata = cmd_word(fcs_pkg::CMD_SUSPEND);
				fcs_pkg::FCS_OP_RESUME: cyc_wdata = cmd_word(fcs_pkg::CMD_ERASE_CONFIRM);
				default: cyc_wdata = wdata_ff;
			endcase
		end else if (state_ff == FCS_SECOND) begin
			case (op_ff)
				fcs_pkg::FCS_OP_ERASE: cyc_wdata = cmd_word(fcs_pkg::CMD_ERASE_CONFIRM);
				fcs_pkg::FCS_OP_CANCEL_PROGRAM:
					cyc_wdata = byte_mode ? fcs_pkg::NULL_BYTE : fcs_pkg::NULL_WORD;
				default: cyc_wdata = wdata_ff;
			endcase
		end
	end

	// state progression
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_ff <= FCS_IDLE;
			op_ff <= fcs_pkg::FCS_OP_NONE;
		end else begin
			case (state_ff)
				FCS_IDLE: begin
					if (go && !refuse) begin
						op_ff <= go_op;
						state_ff <= FCS_FIRST;
					end
				end
				FCS_FIRST: begin
					if (cyc_done) begin
						if (op_ff == fcs_pkg::FCS_OP_PROGRAM || op_ff == fcs_pkg::FCS_OP_ERASE
							|| op_ff == fcs_pkg::FCS_OP_CANCEL_PROGRAM) begin
							state_ff <= FCS_SECOND;
						end else if (op_ff == fcs_pkg::FCS_OP_SUSPEND) begin
							state_ff <= FCS_POLL;
						end else begin
							state_ff <= FCS_IDLE;
						end
					end
				end
				FCS_SECOND: begin
					if (cyc_done) begin
						state_ff <= (op_ff == fcs_pkg::FCS_OP_CANCEL_PROGRAM) ? FCS_IDLE : FCS_POLL;
					end
				end
				FCS_POLL: begin
					if (cyc_done) begin
						state_ff <= FCS_POLL_WAIT;
					end
				end
				FCS_POLL_WAIT: begin
					if (poll_sr[fcs_pkg::READY_BIT]) begin
						state_ff <= FCS_IDLE;
					end else begin
						state_ff <= FCS_POLL;
					end
				end
				default: state_ff <= FCS_IDLE;
			endcase
		end
	end

	// mode tracking of the flash
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			mode_ff <= FCS_MODE_ARRAY;
		end else if (state_ff == FCS_FIRST && cyc_done) begin
			case (op_ff)
				fcs_pkg::FCS_OP_READ_ARRAY: if (mode_ff != FCS_MODE_SUSPEND) mode_ff <= FCS_MODE_ARRAY;
				fcs_pkg::FCS_OP_IDENTIFY: mode_ff <= FCS_MODE_IDENT;
				fcs_pkg::FCS_OP_READ_STATUS,
				fcs_pkg::FCS_OP_RESUME,
				fcs_pkg::FCS_OP_PROGRAM,
				fcs_pkg::FCS_OP_ERASE: mode_ff <= FCS_MODE_STATUS;
				default: mode_ff <= mode_ff;
			endcase
		end else if (state_ff == FCS_POLL_WAIT && op_ff == fcs_pkg::FCS_OP_SUSPEND
			&& poll_sr[fcs_pkg::SUSPEND_BIT]) begin
			mode_ff <= FCS_MODE_SUSPEND;
		end else if (state_ff == FCS_POLL_WAIT && op_ff == fcs_pkg::FCS_OP_ERASE
			&& poll_sr[fcs_pkg::ERASE_FAIL_BIT] && poll_sr[fcs_pkg::READY_BIT]
			&& !poll_sr[fcs_pkg::PROGRAM_FAIL_BIT]) begin
			mode_ff <= FCS_MODE_ARRAY;
		end
	end

	// ------------------------------------------------------------
	// status image, busy and error tracking
	// ------------------------------------------------------------
	always_comb begin
		nxt_status = status_ff;
		if (state_ff == FCS_POLL_WAIT) begin
			nxt_status = low_byte(cyc_rdata);
		end else if (state_ff == FCS_FIRST && cyc_done && op_ff == fcs_pkg::FCS_OP_CLEAR_STATUS) begin
			nxt_status = status_ff & 8'hc7;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			status_ff <= 8'h80;
			busy_ff <= 1'b0;
			erasing_ff <= 1'b0;
			refused_ff <= 1'b0;
			program_supply_high <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			busy_ff <= (state_ff == FCS_POLL) || (state_ff == FCS_POLL_WAIT
				&& !poll_sr[fcs_pkg::READY_BIT]);
			if (go) begin
				refused_ff <= refuse;
			end
			if (state_ff == FCS_FIRST && op_ff == fcs_pkg::FCS_OP_ERASE) begin
				erasing_ff <= 1'b1;
			end else if (state_ff == FCS_POLL_WAIT && op_ff != fcs_pkg::FCS_OP_SUSPEND
				&& poll_sr[fcs_pkg::READY_BIT]) begin
				erasing_ff <= 1'b0;
			end
			if (state_ff == FCS_SECOND) begin
				program_supply_high <= 1'b1;
			end else if (state_ff == FCS_IDLE && mode_ff != FCS_MODE_SUSPEND) begin
				program_supply_high <= 1'b0;
			end
		end
	end

	// data read back, identify, array or status
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rdata_ff <= 16'h0000;
		end else if (state_ff == FCS_FIRST && cyc_done && op_ff == fcs_pkg::FCS_OP_READ) begin
			rdata_ff <= (mode_ff == FCS_MODE_IDENT) ? {8'h00, low_byte(cyc_rdata)} : cyc_rdata;
		end
	end
endmodule

/* rtl/fcs_pkg.sv */
// constants for the flash command sequencer host controller
// assumes a 100 MHz clock and a parallel flash with active-low strobes
package fcs_pkg;
	// ------------------------------------------------------------
	// flash command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_IDENTIFY = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
	localparam logic [7:0] CMD_PROGRAM_SETUP_ALT = 8'h10;
	localparam logic [15:0] NULL_WORD = 16'hffff;
	localparam logic [15:0] NULL_BYTE = 16'h00ff;
	localparam logic [17:0] ID_MAKER_ADDR = 18'h00000;
	localparam logic [17:0] ID_PART_ADDR = 18'h00001;
	// ------------------------------------------------------------
	// status bit positions
	// ------------------------------------------------------------
	localparam int READY_BIT = 7;
	localparam int SUSPEND_BIT = 6;
	localparam int ERASE_FAIL_BIT = 5;
	localparam int PROGRAM_FAIL_BIT = 4;
	localparam int SUPPLY_MISSING_BIT = 3;
	// ------------------------------------------------------------
	// controller register map (avalon word addresses)
	// ------------------------------------------------------------
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_ADDR = 3'h1;
	localparam logic [2:0] REG_WDATA = 3'h2;
	localparam logic [2:0] REG_RDATA = 3'h3;
	localparam logic [2:0] REG_STATUS = 3'h4;
	localparam logic [31:0] UNMAPPED_VALUE = 32'h00000000;
	// ------------------------------------------------------------
	// bus timing on the flash pins
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_LOW_NS = 70;
	localparam int STROBE_HIGH_NS = 30;
	localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	// operations ordered by software
	typedef enum logic [3:0] {
		FCS_OP_READ_ARRAY, FCS_OP_IDENTIFY, FCS_OP_READ_STATUS, FCS_OP_CLEAR_STATUS,
		FCS_OP_PROGRAM, FCS_OP_ERASE, FCS_OP_SUSPEND, FCS_OP_RESUME,
		FCS_OP_READ, FCS_OP_CANCEL_PROGRAM, FCS_OP_NONE
	} fcs_op_t;
endpackage

/* rtl/fcs_bus_cycle.sv */
// one timed write or read cycle on the flash pins
// assumes fcs_pkg; start is taken only while idle is high
module fcs_bus_cycle (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic start,
	input wire logic is_write,
	input wire logic [17:0] addr,
	input wire logic [15:0] wdata,
	output logic idle,
	output logic done,
	output logic [15:0] rdata_ff,
	output logic [17:0] flash_addr_ff,
	output logic [15:0] flash_dq_out_ff,
	output logic flash_dq_oe_ff,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_b_ff,
	output logic flash_we_b_ff,
	output logic flash_oe_b_ff
);
	typedef enum logic [1:0] {FCS_BC_IDLE, FCS_BC_LOW, FCS_BC_HIGH} fcs_bc_t;
	fcs_bc_t state_ff;
	logic [3:0] cnt_ff;
	logic wr_ff;

	assign idle = (state_ff == FCS_BC_IDLE);
	assign done = (state_ff == FCS_BC_HIGH) && (cnt_ff == 4'h0);

	// ------------------------------------------------------------
	// sequencing of strobe low and recovery phases
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_ff <= FCS_BC_IDLE;
			cnt_ff <= 4'h0;
			wr_ff <= 1'b0;
		end else begin
			case (state_ff)
				FCS_BC_IDLE: begin
					if (start) begin
						state_ff <= FCS_BC_LOW;
						cnt_ff <= 4'(fcs_pkg::STROBE_LOW_CYC - 1);
						wr_ff <= is_write;
					end
				end
				FCS_BC_LOW: begin
					if (cnt_ff == 4'h0) begin
						state_ff <= FCS_BC_HIGH;
						cnt_ff <= 4'(fcs_pkg::STROBE_HIGH_CYC - 1);
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				FCS_BC_HIGH: begin
					if (cnt_ff == 4'h0) begin
						state_ff <= FCS_BC_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				default: state_ff <= FCS_BC_IDLE;
			endcase
		end
	end

	// pin drive; data and address latched by the flash on strobe rise
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			flash_ce_b_ff <= 1'b1;
			flash_we_b_ff <= 1'b1;
			flash_oe_b_ff <= 1'b1;
			flash_dq_oe_ff <= 1'b0;
			flash_addr_ff <= 18'h00000;
			flash_dq_out_ff <= 16'h0000;
		end else if (state_ff == FCS_BC_IDLE && start) begin
			flash_ce_b_ff <= 1'b0;
			flash_we_b_ff <= ~is_write;
			flash_oe_b_ff <= is_write;
			flash_dq_oe_ff <= is_write;
			flash_addr_ff <= addr;
			flash_dq_out_ff <= wdata;
		end else if (state_ff == FCS_BC_LOW && cnt_ff == 4'h0) begin
			flash_ce_b_ff <= 1'b1;
			flash_we_b_ff <= 1'b1;
			flash_oe_b_ff <= 1'b1;
		end else if (state_ff == FCS_BC_HIGH && cnt_ff == 4'h0) begin
			flash_dq_oe_ff <= 1'b0; // hold data through the rising edge
		end
	end

	// read data sampled at the end of the access time
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rdata_ff <= 16'h0000;
		end else if (state_ff == FCS_BC_LOW && cnt_ff == 4'h0 && !wr_ff) begin
			rdata_ff <= flash_dq_in;
		end
	end
endmodule

/* verification/fcs_host_properties.sv */
// concurrent checks on the flash pin side and the avalon side of fcs_host
// assumes one clock domain and the sync active-low reset of the host
module fcs_host_properties (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic byte_mode,
	input wire logic [17:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_dq_oe,
	input wire logic [15:0] flash_dq_in,
	input wire logic flash_ce_b,
	input wire logic flash_we_b,
	input wire logic flash_oe_b,
	input wire logic program_supply_high
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	// ------------------------------------------------------------
	// strobe sequences
	// ------------------------------------------------------------
	sequence s_write_low;
		(!flash_we_b)[*7];
	endsequence
	sequence s_recover;
		(flash_we_b && flash_oe_b)[*3];
	endsequence
	// ------------------------------------------------------------
	// pin and avalon rules
	// ------------------------------------------------------------
	a_strobe_exclusive: assert property (!(!flash_we_b && !flash_oe_b))
		else $error("write and read strobes low together");
	a_write_drives: assert property ($fell(flash_we_b) |-> flash_dq_oe && !flash_ce_b)
		else $error("write strobe without bus drive or chip enable");
	a_write_width: assert property ($fell(flash_we_b) |-> s_write_low ##1 flash_we_b)
		else $error("write strobe width wrong");
	a_strobe_recovery: assert property ($rose(flash_we_b) |-> s_recover)
		else $error("write recovery too short");
	a_data_stable: assert property ((!flash_we_b && $past(flash_we_b) == 1'b0) |->
		$stable(flash_dq_out) && $stable(flash_addr))
		else $error("address or data moved during write strobe");
	a_reset_idle: assert property (@(posedge clock) disable iff (1'b0)
		!rst_b |=> flash_we_b && flash_oe_b && flash_ce_b && !flash_dq_oe && !program_supply_high)
		else $error("pins not idle after reset");
	a_wait_ctrl: assert property (avs_waitrequest |->
		avs_write && avs_address == fcs_pkg::REG_CTRL)
		else $error("waitrequest outside a control write");
	a_read_release: assert property ($fell(flash_oe_b) |-> !flash_dq_oe && !flash_ce_b)
		else $error("read strobe while bus driven");
endmodule

bind fcs_host fcs_host_properties fcs_host_properties_i (
	.clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .byte_mode(byte_mode), .flash_addr(flash_addr),
	.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
	.flash_ce_b(flash_ce_b), .flash_we_b(flash_we_b), .flash_oe_b(flash_oe_b),
	.program_supply_high(program_supply_high)
);

/* verification/fcs_flash_model.sv */
// behavioural flash device: command decode, status flags, 64-word array
// assumes pins sampled on the host clock; supply_ok models the supply rail
module fcs_flash_model #(
	parameter int BUSY_CYC = 20,
	parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
	parameter logic [7:0] PART_ID = 8'h3c // arbitrary value
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [17:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_ce_b,
	input wire logic flash_we_b,
	input wire logic flash_oe_b,
	input wire logic program_supply_high,
	input wire logic byte_mode,
	input wire logic supply_ok,
	output logic [15:0] flash_dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem_ff [64];
	logic [2:0] mode_ff; // 0 array, 1 ident, 2 status, 3 program setup, 4 erase setup
	logic [2:0] err_ff; // erase fail, program fail, supply missing
	int cnt_ff;
	logic ers_ff, pend_ff;
	logic [5:0] pa_ff, la_ff;
	logic [15:0] pd_ff, ld_ff, last_ff, rdv;
	logic [7:0] sr;
	logic vpp;
	assign sr = {cnt_ff == 0, 1'b0, err_ff, 3'b000};
	assign vpp = program_supply_high && supply_ok;
	always_comb begin
		if (cnt_ff != 0 || mode_ff >= 3'd2) rdv = {8'h00, sr};
		else if (mode_ff == 3'd1) rdv = {8'h00, flash_addr[0] ? PART_ID : MAKER_ID};
		else rdv = mem_ff[flash_addr[5:0]];
	end
	// released bus shows the inverse of the last value
	assign flash_dq_in = (!flash_ce_b && !flash_oe_b) ? rdv : ~last_ff;
	always_ff @(posedge clock) begin
		if (!flash_ce_b && !flash_oe_b) last_ff <= rdv;
	end
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			mode_ff <= 3'd0;
			err_ff <= 3'b000;
			cnt_ff <= 0;
			pend_ff <= 1'b0;
			for (int i = 0; i < 64; i++) mem_ff[i] <= 16'hf0f0;
		end else begin
			if (!flash_ce_b && !flash_we_b) begin
				la_ff <= flash_addr[5:0];
				ld_ff <= flash_dq_out;
				pend_ff <= 1'b1;
			end else if (pend_ff) begin
				pend_ff <= 1'b0;
				if (cnt_ff == 0) begin
					if (mode_ff == 3'd3) begin
						if (byte_mode ? ld_ff[7:0] == 8'hff : ld_ff == 16'hffff) mode_ff <= 3'd0;
						else if (!vpp) err_ff <= err_ff | 3'b011;
						else begin
							pa_ff <= la_ff;
							pd_ff <= ld_ff;
							ers_ff <= 1'b0;
							cnt_ff <= BUSY_CYC;
						end
						if (!(byte_mode ? ld_ff[7:0] == 8'hff : ld_ff == 16'hffff)) mode_ff <= 3'd2;
					end else if (mode_ff == 3'd4) begin
						mode_ff <= (ld_ff[7:0] != 8'hd0) ? 3'd0 : 3'd2;
						if (ld_ff[7:0] != 8'hd0) err_ff[2] <= 1'b1;
						else if (!vpp) err_ff <= err_ff | 3'b101;
						else begin
							pa_ff <= la_ff;
							ers_ff <= 1'b1;
							cnt_ff <= BUSY_CYC;
						end
					end else begin
						case (ld_ff[7:0])
							8'hff: mode_ff <= 3'd0;
							8'h90: mode_ff <= 3'd1;
							8'h70: mode_ff <= 3'd2;
							8'h50: err_ff <= 3'b000;
							8'h40, 8'h10: mode_ff <= err_ff[0] ? 3'd2 : 3'd3;
							8'h20: mode_ff <= err_ff[0] ? 3'd2 : 3'd4;
							default: ;
						endcase
					end
				end
			end
			if (cnt_ff == 1) begin
				if (ers_ff) begin
					for (int i = 0; i < 64; i++) if (i[5:4] == pa_ff[5:4]) mem_ff[i] <= 16'hffff;
				end else mem_ff[pa_ff] <= mem_ff[pa_ff] & pd_ff;
			end
			if (cnt_ff != 0) cnt_ff <= cnt_ff - 1;
		end
	end
endmodule

/* verification/fcs_host_tb.sv */
// self-checking bench for fcs_host against the flash model
// assumes fcs_pkg register map and op codes; avalon master below
module fcs_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
	localparam logic [7:0] PART = 8'h3c; // arbitrary value
	logic clock, rst_b, avs_read, avs_write, avs_waitrequest, byte_mode, supply_ok;
	logic [2:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [17:0] flash_addr;
	logic [15:0] flash_dq_out, flash_dq_in;
	logic flash_dq_oe, flash_ce_b, flash_we_b, flash_oe_b, program_supply_high;
	int failures, comparisons;
	fcs_host fcs_host_i (.clock(clock), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .byte_mode(byte_mode),
		.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
		.flash_dq_in(flash_dq_in), .flash_ce_b(flash_ce_b), .flash_we_b(flash_we_b),
		.flash_oe_b(flash_oe_b), .program_supply_high(program_supply_high));
	fcs_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) fcs_flash_model_i (.clock(clock),
		.rst_b(rst_b), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
		.flash_ce_b(flash_ce_b), .flash_we_b(flash_we_b), .flash_oe_b(flash_oe_b),
		.program_supply_high(program_supply_high), .byte_mode(byte_mode),
		.supply_ok(supply_ok), .flash_dq_in(flash_dq_in));
	// clock generation
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clock);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 3000);
		if (avs_waitrequest !== 1'b0) failures++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// order one operation and wait until busy clears
	task automatic op(input fcs_pkg::fcs_op_t c, input logic [17:0] a, input logic [15:0] d);
		logic [31:0] q;
		int n;
		bus(1'b1, fcs_pkg::REG_ADDR, {14'h0, a}, q);
		bus(1'b1, fcs_pkg::REG_WDATA, {16'h0, d}, q);
		bus(1'b1, fcs_pkg::REG_CTRL, {28'h0, c}, q);
		n = 0;
		do begin
			bus(1'b0, fcs_pkg::REG_STATUS, 32'h0, q);
			n++;
		end while (q[9] !== 1'b0 && n < 500);
		chk("operation finished", {31'h0, q[9]}, 32'h0);
	endtask
	task automatic rd(input logic [17:0] a, output logic [31:0] q);
		op(fcs_pkg::FCS_OP_READ, a, 16'h0);
		bus(1'b0, fcs_pkg::REG_RDATA, 32'h0, q);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] q;
		bus(1'b0, fcs_pkg::REG_STATUS, 32'h0, q);
		chk("status after reset", {20'h0, q[11:0]}, 32'h80);
		bus(1'b0, 3'h5, 32'h0, q);
		chk("unmapped read", q, fcs_pkg::UNMAPPED_VALUE);
		rd(18'h3, q);
		chk("array after reset", {16'h0, q[15:0]}, 32'hf0f0);
	endtask
	task automatic t_ident;
		logic [31:0] q;
		op(fcs_pkg::FCS_OP_IDENTIFY, 18'h0, 16'h0);
		rd(fcs_pkg::ID_MAKER_ADDR, q);
		chk("maker byte", {24'h0, q[7:0]}, {24'h0, MAKER});
		rd(fcs_pkg::ID_PART_ADDR, q);
		chk("part byte", {24'h0, q[7:0]}, {24'h0, PART});
		op(fcs_pkg::FCS_OP_READ_ARRAY, 18'h0, 16'h0);
		rd(18'h2, q);
		chk("array after identify", {16'h0, q[15:0]}, 32'hf0f0);
	endtask
	task automatic t_program;
		logic [31:0] q;
		op(fcs_pkg::FCS_OP_PROGRAM, 18'h5, 16'h0ff0);
		bus(1'b0, fcs_pkg::REG_STATUS, 32'h0, q);
		chk("status after program", {24'h0, q[7:0]}, 32'h80);
		rd(18'h5, q);
		chk("status mode read", {24'h0, q[7:0]}, 32'h80);
		op(fcs_pkg::FCS_OP_READ_ARRAY, 18'h0, 16'h0);
		rd(18'h5, q);
		chk("programmed word", {16'h0, q[15:0]}, 32'h00f0);
	endtask
	task automatic t_cancel;
		logic [31:0] q;
		for (int bm = 0; bm < 2; bm++) begin
			byte_mode <= bm[0];
			op(fcs_pkg::FCS_OP_CANCEL_PROGRAM, 18'h6, 16'h0);
			op(fcs_pkg::FCS_OP_READ_ARRAY, 18'h0, 16'h0);
			rd(18'h6, q);
			chk("cancelled word", {16'h0, q[15:0]}, 32'hf0f0);
		end
	endtask
	task automatic t_erase;
		logic [31:0] q;
		bus(1'b1, fcs_pkg::REG_ADDR, 32'h12, q);
		bus(1'b1, fcs_pkg::REG_CTRL, {28'h0, fcs_pkg::FCS_OP_ERASE}, q);
		// this control write stalls on waitrequest until the erase ends
		op(fcs_pkg::FCS_OP_READ_STATUS, 18'h12, 16'h0);
		rd(18'h12, q);
		chk("status after erase", {24'h0, q[7:0]}, 32'h80);
		op(fcs_pkg::FCS_OP_READ_ARRAY, 18'h0, 16'h0);
		rd(18'h13, q);
		chk("erased word", {16'h0, q[15:0]}, 32'hffff);
		rd(18'h5, q);
		chk("word outside block", {16'h0, q[15:0]}, 32'h00f0);
	endtask
	task automatic t_supply;
		logic [31:0] q;
		supply_ok <= 1'b0;
		op(fcs_pkg::FCS_OP_PROGRAM, 18'h7, 16'h0);
		bus(1'b0, fcs_pkg::REG_STATUS, 32'h0, q);
		chk("supply error status", {24'h0, q[7:0]}, 32'h98);
		supply_ok <= 1'b1;
		op(fcs_pkg::FCS_OP_PROGRAM, 18'h7, 16'h0);
		bus(1'b0, fcs_pkg::REG_STATUS, 32'h0, q);
		chk("program refused", {31'h0, q[11]}, 32'h1);
		op(fcs_pkg::FCS_OP_ERASE, 18'h21, 16'h0);
		op(fcs_pkg::FCS_OP_READ_ARRAY, 18'h0, 16'h0);
		rd(18'h7, q);
		chk("refused program", {16'h0, q[15:0]}, 32'hf0f0);
		rd(18'h20, q);
		chk("refused erase", {16'h0, q[15:0]}, 32'hf0f0);
		op(fcs_pkg::FCS_OP_CLEAR_STATUS, 18'h0, 16'h0);
		op(fcs_pkg::FCS_OP_READ_STATUS, 18'h0, 16'h0);
		rd(18'h0, q);
		chk("flags cleared", {24'h0, q[7:0]}, 32'h80);
	endtask
	// ------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ------------------------------------------------------------
	task automatic give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		give_verdict();
	end
	initial begin
		failures = 0;
		comparisons = 0;
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 3'h0;
		avs_writedata = 32'h0;
		byte_mode = 1'b0;
		supply_ok = 1'b1;
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		t_reset();
		t_ident();
		t_program();
		t_cancel();
		t_erase();
		t_supply();
		give_verdict();
	end
endmodule
